// file: design/lmhc_regs.svh
// Register offsets, field positions, codes and reset values of the loop mode block.
// Included by the package users; holds definitions only.
`ifndef LMHC_REGS_SVH
`define LMHC_REGS_SVH

// Byte addresses on the register bus
`define LMHC_ADDR_MODE     12'h000
`define LMHC_ADDR_RETAIN   12'h004
`define LMHC_ADDR_STATUS   12'h008
`define LMHC_ADDR_MASK     12'h00C
`define LMHC_ADDR_STATE    12'h010
`define LMHC_ADDR_ERRCODE  12'h014
`define LMHC_ADDR_STOPW1   12'h118
`define LMHC_ADDR_STOPW2   12'h148
`define LMHC_ADDR_STOPW3   12'h178
`define LMHC_ADDR_STOPW4   12'h1A8

// Loop mode codes
`define LMHC_MODE_MAX      3'h4
`define LMHC_MODE_RESET    3'h0

// Error codes
`define LMHC_ERR_MODE_CHG  16'h000D
`define LMHC_ERR_WR_DATA   16'h0001
`define LMHC_ERR_NONE      16'h0000

// Stop behaviour word: largest legal value and reset value
`define LMHC_STOPW_MAX     16'h0002
`define LMHC_STOPW_RESET   16'h0000

// Retain/clear bits: 0 clear, 1 retain
`define LMHC_RETAIN_RESET  4'h0

// Status bits, one per event
`define LMHC_EV_MODE_ERR   0
`define LMHC_EV_WR_ERR     1
`define LMHC_EV_STOP_ERR   2
`define LMHC_EV_RUN_STOP   3
`define LMHC_EV_LINK_LOST  4
`define LMHC_EV_W          5

// State register fields
`define LMHC_ST_MODE_LSB   0
`define LMHC_ST_PEND_LSB   4
`define LMHC_ST_ERR_BIT    8
`define LMHC_ST_RUN_LSB    12

`endif

// file: design/lmhc_pkg.sv
// Types shared by the loop mode block.
// Assumes lmhc_regs.svh for the numeric constants.
package lmhc_pkg;

    // Module-wide loop mode, in code order 0 to 4
    typedef enum logic [2:0] {
        LMHC_STD,
        LMHC_HC_NORM,
        LMHC_HC_EXP,
        LMHC_MIX_NORM,
        LMHC_MIX_EXP
    } lmhc_mode_t;

    // What one channel does in the selected mode
    typedef enum logic [1:0] {
        LMHC_KIND_NONE,
        LMHC_KIND_STD,
        LMHC_KIND_HC
    } lmhc_kind_t;

endpackage

// file: design/lmhc_sync.sv
// Two-flop synchroniser for a group of level inputs.
// Assumes the inputs are asynchronous to CLK; only the second flop is read.
`timescale 1ns/1ps
module lmhc_sync #(
    parameter int W = 1
) (
    input wire logic clk, // Module clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic [W-1:0] d, // Asynchronous levels
    output logic [W-1:0] q // Synchronised levels
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// file: design/lmhc_chan.sv
// One channel's output gating: control kind, external flags and fault response.
// Assumes demands come from the control core on the same clock.
`timescale 1ns/1ps
module lmhc_chan
    import lmhc_pkg::*;
(
    input wire logic clk, // Module clock
    input wire logic reset, // Synchronous reset, active high
    input lmhc_kind_t kind, // Control kind in the active mode
    input wire logic use_ext, // Outputs go to the external output module
    input wire logic retain, // 1 retain, 0 clear
    input wire logic stop_err, // Controller stop error level
    input wire logic link_lost, // Network communication lost level
    input wire logic in_stop, // Controller in stop after run
    input wire logic heat_req, // Heating demand from control core
    input wire logic cool_req, // Cooling demand from control core
    output logic heat_o, // Local heating output
    output logic cool_o, // Local cooling output
    output logic ext_heat_o, // Heating flag for external module
    output logic ext_cool_o, // Cooling flag for external module
    output logic run_mon_o // Channel operation monitor
);
    // Clear channels halt on any fault; retain channels ignore all three
    wire halt_fault = !retain && (stop_err || link_lost);
    wire halt_stop = !retain && in_stop;
    wire active = (kind != LMHC_KIND_NONE) && !halt_fault && !halt_stop;
    // Standard control has a single output, so cooling stays off
    wire heat_d = active && heat_req;
    wire cool_d = active && (kind == LMHC_KIND_HC) && cool_req;

    // Local pins are unused when the channel is routed out
    always_ff @(posedge clk) begin
        if (reset) begin
            heat_o <= 1'b0;
            cool_o <= 1'b0;
            ext_heat_o <= 1'b0;
            ext_cool_o <= 1'b0;
            run_mon_o <= 1'b0;
        end else begin
            heat_o <= heat_d && !use_ext;
            cool_o <= cool_d && !use_ext;
            ext_heat_o <= heat_d && use_ext;
            ext_cool_o <= cool_d && use_ext;
            run_mon_o <= active;
        end
    end
endmodule

// file: design/lmhc_top.sv
// Loop mode selection and fault-response output gating of a four-channel
// temperature control module, with an Avalon-MM register slave.
// Assumes fault and backup levels arrive from the network side asynchronously,
// and control demands arrive from the control core on CLK.
//
// Behaviour
// - Mode code 0..4 selects standard, HC normal, HC expanded, mix normal, mix expanded.
// - Standard mode runs standard control on all four channels.
// - HC normal: channels 1 and 2 heating-cooling; channels 3 and 4 idle.
// - HC expanded: all four heating-cooling; 3 and 4 via external module.
// - Mix normal: channel 1 heating-cooling, 3 and 4 standard, 2 idle.
// - Mix expanded: 1 and 2 heating-cooling, 2 external; 3 and 4 standard.
// - Idle channels still measure temperature but drive no control output.
// - Changing the mode raises error code 000DH at once.
// - A high-then-low backup request stores new settings and clears the error.
// - External heating/cooling flags active only for expanded-mode routed channels.
// - In normal modes the external flag positions are never driven.
// - Write-data errors handled normally regardless of retain setting.
// - Clear channel: stop error or link loss halts control and external outputs.
// - Retain channel: stop error, run-to-stop or link loss do not interrupt it.
// - Clear channel: run-to-stop applies that channel's stop behaviour word.
// - Clear channel entering stop behaviour drops its operation monitor flag.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "lmhc_regs.svh"
module lmhc_top
    import lmhc_pkg::*;
(
    input wire logic CLK, // Module clock, 40 MHz
    input wire logic RESET, // Synchronous reset, active high
    input wire logic [11:0] AVS_ADDRESS, // Byte address
    input wire logic AVS_READ, // Read request
    input wire logic AVS_WRITE, // Write request
    input wire logic [3:0] AVS_BYTEENABLE, // Write byte lanes
    input wire logic [31:0] AVS_WRITEDATA, // Write data
    output logic [31:0] AVS_READDATA, // Read data
    output logic AVS_WAITREQUEST, // Stall, high until answer
    input wire logic CPU_STOP_ERR, // Controller stop error, async level
    input wire logic CPU_STOPPED, // Controller not running, async level
    input wire logic LINK_LOST, // Network communication lost, async level
    input wire logic BACKUP_REQ, // Setting backup request, async level
    input wire logic [3:0] HEAT_REQ, // Heating demands per channel
    input wire logic [3:0] COOL_REQ, // Cooling demands per channel
    output logic [3:0] HEAT_OUT, // Local heating outputs
    output logic [3:0] COOL_OUT, // Local cooling outputs
    output logic [3:0] EXT_HEAT_FLAG, // Heating flags for external module
    output logic [3:0] EXT_COOL_FLAG, // Cooling flags for external module
    output logic [3:0] RUN_MON, // Channel operation monitor flags
    output logic [7:0] APPLIED_STOP, // Stop behaviour applied, 2 bits per channel
    output logic ERR_ACTIVE, // Error condition present
    output logic [15:0] ERR_CODE, // Current error code
    output logic IRQ // Interrupt, level
);
    // Synchronised network-side levels
    logic [3:0] sync_q;
    wire stop_err_s = sync_q[0];
    wire stopped_s = sync_q[1];
    wire lost_s = sync_q[2];
    wire backup_s = sync_q[3];

    lmhc_sync #(.W(4)) u_sync (
        .clk(CLK),
        .reset(RESET),
        .d({BACKUP_REQ, LINK_LOST, CPU_STOPPED, CPU_STOP_ERR}),
        .q(sync_q)
    );

    // Register state
    lmhc_mode_t mode_act_q;
    lmhc_mode_t mode_pend_q;
    logic err_q;
    logic [15:0] err_code_q;
    logic [3:0] retain_q;
    logic [15:0] stopw_q [4];
    logic [`LMHC_EV_W-1:0] sts_q;
    logic [`LMHC_EV_W-1:0] mask_q;
    logic [7:0] applied_q;
    logic prev_stopped_q;
    logic prev_err_q;
    logic prev_lost_q;
    logic prev_backup_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic irq_q;

    // Bus handshake: data loaded on the first edge, request completes on the second
    wire req = AVS_READ || AVS_WRITE;
    wire done = req && !wait_q;
    wire wr_done = done && AVS_WRITE;
    wire rd_done = done && AVS_READ;
    wire [31:0] wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                         {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

    // Address decode
    wire sel_mode = AVS_ADDRESS == `LMHC_ADDR_MODE;
    wire sel_retain = AVS_ADDRESS == `LMHC_ADDR_RETAIN;
    wire sel_status = AVS_ADDRESS == `LMHC_ADDR_STATUS;
    wire sel_mask = AVS_ADDRESS == `LMHC_ADDR_MASK;
    wire sel_state = AVS_ADDRESS == `LMHC_ADDR_STATE;
    wire sel_errcode = AVS_ADDRESS == `LMHC_ADDR_ERRCODE;
    wire [3:0] sel_stopw = {AVS_ADDRESS == `LMHC_ADDR_STOPW4, AVS_ADDRESS == `LMHC_ADDR_STOPW3,
                            AVS_ADDRESS == `LMHC_ADDR_STOPW2, AVS_ADDRESS == `LMHC_ADDR_STOPW1};

    // Write values merged with byte lanes; out-of-range values are write-data errors
    wire [31:0] mode_merge = (32'({mode_pend_q}) & ~wmask) | (AVS_WRITEDATA & wmask);
    wire [2:0] mode_wval = mode_merge[2:0];
    wire mode_bad = mode_merge > 32'(`LMHC_MODE_MAX);
    wire mode_wr = wr_done && sel_mode && !mode_bad;
    wire mode_chg = mode_wr && (mode_wval != 3'(mode_pend_q));
    wire [1:0] stopw_idx = sel_stopw[3] ? 2'h3 : sel_stopw[2] ? 2'h2 : sel_stopw[1] ? 2'h1 : 2'h0;
    wire [15:0] stopw_merge = (stopw_q[stopw_idx] & ~wmask[15:0]) | (AVS_WRITEDATA[15:0] & wmask[15:0]);
    wire stopw_bad = stopw_merge > `LMHC_STOPW_MAX;
    wire stopw_wr = wr_done && (sel_stopw != 4'h0) && !stopw_bad;
    wire wr_err = wr_done && ((sel_mode && mode_bad) || ((sel_stopw != 4'h0) && stopw_bad));

    // Backup request completes on its falling edge
    wire backup_fall = prev_backup_q && !backup_s;

    // Fault edges for interrupts and stop behaviour capture
    wire run_to_stop = stopped_s && !prev_stopped_q;
    wire stop_err_rise = stop_err_s && !prev_err_q;
    wire lost_rise = lost_s && !prev_lost_q;
    wire [`LMHC_EV_W-1:0] ev = {lost_rise, run_to_stop, stop_err_rise, wr_err, mode_chg};
    wire sts_rd = rd_done && sel_status;
    // A read clears only the bits it reported, so an event landing in its first cycle survives
    wire [`LMHC_EV_W-1:0] sts_keep = sts_rd ? (sts_q & ~rdata_q[`LMHC_EV_W-1:0]) : sts_q;

    // Per-channel control kind from the active mode
    lmhc_kind_t kind [4];
    logic [3:0] use_ext;
    assign kind[0] = (mode_act_q == LMHC_STD) ? LMHC_KIND_STD : LMHC_KIND_HC;
    assign kind[1] = (mode_act_q == LMHC_STD) ? LMHC_KIND_STD :
                     (mode_act_q == LMHC_MIX_NORM) ? LMHC_KIND_NONE : LMHC_KIND_HC;
    assign kind[2] = (mode_act_q == LMHC_HC_NORM) ? LMHC_KIND_NONE :
                     (mode_act_q == LMHC_HC_EXP) ? LMHC_KIND_HC : LMHC_KIND_STD;
    assign kind[3] = kind[2];
    // Only expanded modes route channels to the external output module
    assign use_ext[0] = 1'b0;
    assign use_ext[1] = mode_act_q == LMHC_MIX_EXP;
    assign use_ext[2] = mode_act_q == LMHC_HC_EXP;
    assign use_ext[3] = use_ext[2];

    // Read data selection; unmapped addresses read zero
    wire [31:0] state_word = (32'({mode_act_q}) << `LMHC_ST_MODE_LSB) |
                             (32'({mode_pend_q}) << `LMHC_ST_PEND_LSB) |
                             (32'(err_q) << `LMHC_ST_ERR_BIT) |
                             (32'(RUN_MON) << `LMHC_ST_RUN_LSB);
    wire [31:0] rd_mux = sel_mode ? 32'({mode_pend_q}) :
                         sel_retain ? 32'(retain_q) :
                         sel_status ? 32'(sts_q) :
                         sel_mask ? 32'(mask_q) :
                         sel_state ? state_word :
                         sel_errcode ? 32'(err_code_q) :
                         (sel_stopw != 4'h0) ? 32'(stopw_q[stopw_idx]) : 32'h0000_0000;

    // Bus slave timing: waitrequest drops one cycle after the request appears
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= !(req && wait_q);
            if (req && wait_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Edge-detect history
    always_ff @(posedge CLK) begin
        if (RESET) begin
            prev_stopped_q <= 1'b0;
            prev_err_q <= 1'b0;
            prev_lost_q <= 1'b0;
            prev_backup_q <= 1'b0;
        end else begin
            prev_stopped_q <= stopped_s;
            prev_err_q <= stop_err_s;
            prev_lost_q <= lost_s;
            prev_backup_q <= backup_s;
        end
    end

    // Mode: the written code waits in pending until a backup request commits it
    always_ff @(posedge CLK) begin
        if (RESET) begin
            mode_act_q <= lmhc_mode_t'(`LMHC_MODE_RESET);
            mode_pend_q <= lmhc_mode_t'(`LMHC_MODE_RESET);
        end else begin
            if (mode_wr) begin
                mode_pend_q <= lmhc_mode_t'(mode_wval);
            end
            if (backup_fall) begin
                mode_act_q <= mode_pend_q;
            end
        end
    end

    // Error state: a new error in the backup cycle outlives the clear
    always_ff @(posedge CLK) begin
        if (RESET) begin
            err_q <= 1'b0;
            err_code_q <= `LMHC_ERR_NONE;
        end else if (mode_chg) begin
            err_q <= 1'b1;
            err_code_q <= `LMHC_ERR_MODE_CHG;
        end else if (wr_err) begin
            err_q <= 1'b1;
            err_code_q <= `LMHC_ERR_WR_DATA;
        end else if (backup_fall) begin
            err_q <= 1'b0;
            err_code_q <= `LMHC_ERR_NONE;
        end
    end

    // Retain bits and interrupt mask
    always_ff @(posedge CLK) begin
        if (RESET) begin
            retain_q <= `LMHC_RETAIN_RESET;
            mask_q <= '0;
        end else if (wr_done) begin
            if (sel_retain && AVS_BYTEENABLE[0]) begin
                retain_q <= AVS_WRITEDATA[3:0];
            end
            if (sel_mask && AVS_BYTEENABLE[0]) begin
                mask_q <= AVS_WRITEDATA[`LMHC_EV_W-1:0];
            end
        end
    end

    // Stop behaviour words, one per channel
    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < 4; i++) begin
                stopw_q[i] <= `LMHC_STOPW_RESET;
            end
        end else if (stopw_wr) begin
            stopw_q[stopw_idx] <= stopw_merge;
        end
    end

    // Stop behaviour applied to clear channels on a run-to-stop edge
    always_ff @(posedge CLK) begin
        if (RESET) begin
            applied_q <= 8'h00;
        end else if (run_to_stop) begin
            for (int i = 0; i < 4; i++) begin
                applied_q[2*i +: 2] <= retain_q[i] ? 2'h0 : stopw_q[i][1:0];
            end
        end
    end

    // Sticky status, cleared by reading it; a new event wins over the clear
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sts_q <= '0;
            irq_q <= 1'b0;
        end else begin
            sts_q <= sts_keep | ev;
            irq_q <= |((sts_keep | ev) & mask_q);
        end
    end

    // Channel gating, one instance per channel
    for (genvar c = 0; c < 4; c++) begin : g_chan
        lmhc_chan u_chan (
            .clk(CLK),
            .reset(RESET),
            .kind(kind[c]),
            .use_ext(use_ext[c]),
            .retain(retain_q[c]),
            .stop_err(stop_err_s),
            .link_lost(lost_s),
            .in_stop(stopped_s),
            .heat_req(HEAT_REQ[c]),
            .cool_req(COOL_REQ[c]),
            .heat_o(HEAT_OUT[c]),
            .cool_o(COOL_OUT[c]),
            .ext_heat_o(EXT_HEAT_FLAG[c]),
            .ext_cool_o(EXT_COOL_FLAG[c]),
            .run_mon_o(RUN_MON[c])
        );
    end

    // Top outputs straight from flops
    assign AVS_READDATA = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign APPLIED_STOP = applied_q;
    assign ERR_ACTIVE = err_q;
    assign ERR_CODE = err_code_q;
    assign IRQ = irq_q;
endmodule

// file: verification/lmhc_plc_model.sv
// Controller-side model: drives fault levels and the setting backup request.
// Assumes the bench calls its tasks just after a rising edge of clk.
`timescale 1ns/1ps
module lmhc_plc_model (
    input wire logic clk, // Module clock
    output logic stop_err, // Controller stop error level
    output logic stopped, // Controller not running level
    output logic link_lost, // Network communication lost level
    output logic backup_req // Setting backup request level
);
    // Quiet controller at time zero
    initial begin
        stop_err = 1'b0;
        stopped = 1'b0;
        link_lost = 1'b0;
        backup_req = 1'b0;
    end

    // Fault levels move together on one edge, as the network refresh would
    task automatic set_levels(input logic se, input logic st, input logic ll);
        @(posedge clk);
        stop_err <= se;
        stopped <= st;
        link_lost <= ll;
    endtask

    // High then low; held four cycles so the two-flop sync cannot miss it
    task automatic pulse_backup();
        @(posedge clk);
        backup_req <= 1'b1;
        repeat (4) @(posedge clk);
        backup_req <= 1'b0;
    endtask
endmodule

// file: verification/lmhc_top_asserts.sv
// Concurrent checks on the ports of the loop mode block.
// Assumes the bench writes whole words with all byte lanes enabled.
`timescale 1ns/1ps
`include "lmhc_regs.svh"
module lmhc_top_asserts (
    input wire logic CLK, // Module clock
    input wire logic RESET, // Synchronous reset, active high
    input wire logic [11:0] AVS_ADDRESS, // Byte address
    input wire logic AVS_READ, // Read request
    input wire logic AVS_WRITE, // Write request
    input wire logic [3:0] AVS_BYTEENABLE, // Write byte lanes
    input wire logic [31:0] AVS_WRITEDATA, // Write data
    input wire logic AVS_WAITREQUEST, // Stall
    input wire logic CPU_STOP_ERR, // Controller stop error
    input wire logic CPU_STOPPED, // Controller not running
    input wire logic LINK_LOST, // Communication lost
    input wire logic [3:0] HEAT_OUT, // Local heating outputs
    input wire logic [3:0] COOL_OUT, // Local cooling outputs
    input wire logic [3:0] EXT_HEAT_FLAG, // External heating flags
    input wire logic [3:0] EXT_COOL_FLAG, // External cooling flags
    input wire logic [3:0] RUN_MON, // Operation monitor flags
    input wire logic ERR_ACTIVE, // Error present
    input wire logic [15:0] ERR_CODE, // Error code
    input wire logic IRQ // Interrupt
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // Decode of accepted whole-word writes
    wire wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE == 4'hF;
    wire mode_wr = wr_ok && AVS_ADDRESS == `LMHC_ADDR_MODE;
    wire mode_ok = AVS_WRITEDATA <= 32'h4;
    logic [2:0] pend_q;
    logic [3:0] ret_q;
    logic [4:0] mask_q;

    // Shadow copies; they lag nothing since the design also commits at this edge
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pend_q <= 3'h0;
            ret_q <= 4'h0;
            mask_q <= 5'h00;
        end else begin
            if (mode_wr && mode_ok) pend_q <= AVS_WRITEDATA[2:0];
            if (wr_ok && AVS_ADDRESS == `LMHC_ADDR_RETAIN) ret_q <= AVS_WRITEDATA[3:0];
            if (wr_ok && AVS_ADDRESS == `LMHC_ADDR_MASK) mask_q <= AVS_WRITEDATA[4:0];
        end
    end

    err_code_match_a: assert property (ERR_ACTIVE == (ERR_CODE != 16'h0000))
        else $error("error flag and error code disagree");
    mode_err_raise_a: assert property (mode_wr && mode_ok && AVS_WRITEDATA[2:0] != pend_q
        |=> ERR_ACTIVE && ERR_CODE == `LMHC_ERR_MODE_CHG) else $error("mode change raised no error");
    wait_one_cycle_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("request not answered after one wait cycle");
    wait_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    wait_needs_req_a: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ) || $past(AVS_WRITE))
        else $error("waitrequest low without a request");
    irq_mask_gate_a: assert property ((mask_q == 5'h00)[*2] |-> !IRQ)
        else $error("interrupt high with all sources masked");
    ch1_never_ext_a: assert property (EXT_HEAT_FLAG[0] == 1'b0 && EXT_COOL_FLAG[0] == 1'b0)
        else $error("channel 1 drove an external flag");
    ext_local_excl_a: assert property (((EXT_HEAT_FLAG | EXT_COOL_FLAG) & (HEAT_OUT | COOL_OUT)) == 4'h0)
        else $error("channel drove local and external outputs together");
    clear_halt_a: assert property ((!ret_q[0] && (LINK_LOST || CPU_STOP_ERR))[*4]
        |-> {HEAT_OUT[0], COOL_OUT[0], RUN_MON[0]} == 3'b000) else $error("cleared channel kept running on fault");
    stop_mon_off_a: assert property ((!ret_q[2] && CPU_STOPPED)[*4]
        |-> !RUN_MON[2] && !HEAT_OUT[2] && !EXT_HEAT_FLAG[2]) else $error("cleared channel ran in stop");

    // Main scenarios reached
    mode_err_c: cover property (mode_wr && mode_ok && AVS_WRITEDATA[2:0] != pend_q);
    irq_c: cover property (IRQ);
    halt_c: cover property (!ret_q[0] && LINK_LOST ##4 !RUN_MON[0]);
    ext_c: cover property (EXT_HEAT_FLAG != 4'h0);
endmodule

bind lmhc_top lmhc_top_asserts u_chk (.*);

// file: verification/lmhc_top_tb.sv
// Self-checking bench for the loop mode block: registers, modes, errors, faults.
// Assumes the controller model in lmhc_plc_model.sv and the register map header.
`timescale 1ns/1ps
`include "lmhc_regs.svh"
module lmhc_top_tb;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic [11:0] AVS_ADDRESS = 12'h000;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0] HEAT_REQ = 4'h0;
    logic [3:0] COOL_REQ = 4'h0;
    logic [31:0] AVS_READDATA, rd;
    logic AVS_WAITREQUEST, ERR_ACTIVE, IRQ, stop_err, stopped, link_lost, backup_req;
    logic [3:0] HEAT_OUT, COOL_OUT, EXT_HEAT_FLAG, EXT_COOL_FLAG, RUN_MON;
    logic [7:0] APPLIED_STOP;
    logic [15:0] ERR_CODE;
    int err_total = 0;
    int num_checks = 0;

    // 40 MHz clock
    always #12.5 CLK = ~CLK;

    lmhc_top dut (.AVS_BYTEENABLE(4'hF), .CPU_STOP_ERR(stop_err), .CPU_STOPPED(stopped), .LINK_LOST(link_lost),
        .BACKUP_REQ(backup_req), .*);
    lmhc_plc_model plc (.clk(CLK), .stop_err(stop_err), .stopped(stopped), .link_lost(link_lost),
        .backup_req(backup_req));

    // Compare with case equality so an unknown never passes
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon access, held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(posedge CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
        if (n >= 40) chk("waitrequest", 32'h0, 32'(AVS_WAITREQUEST));
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask

    // Let edges land, then sample mid-cycle
    task automatic settle(input int n);
        repeat (n) @(posedge CLK);
        @(negedge CLK);
    endtask

    task automatic drive_req(input logic [3:0] h, input logic [3:0] c);
        @(posedge CLK);
        HEAT_REQ <= h;
        COOL_REQ <= c;
    endtask

    task automatic t_reset_values();
        logic [11:0] a [8] = '{`LMHC_ADDR_MODE, `LMHC_ADDR_RETAIN, `LMHC_ADDR_MASK, `LMHC_ADDR_ERRCODE,
            `LMHC_ADDR_STOPW1, `LMHC_ADDR_STOPW2, `LMHC_ADDR_STOPW3, `LMHC_ADDR_STOPW4};
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, a[i], 32'h0);
            chk("reset value", 32'h0, rd);
        end
        bus(1'b1, 12'h020, 32'hFFFFFFFF);
        bus(1'b0, 12'h020, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("test reset_values done");
    endtask

    // Every mode code in turn; table nibbles are heat, cool, ext heat, ext cool with all demands high
    task automatic t_mode_table();
        logic [15:0] tab [5] = '{16'hF000, 16'h3300, 16'h33CC, 16'hD100, 16'hD122};
        logic [2:0] mi;
        bus(1'b1, `LMHC_ADDR_MASK, 32'h1);
        drive_req(4'hF, 4'hF);
        for (int m = 1; m <= 5; m++) begin
            mi = 3'(m % 5);
            bus(1'b1, `LMHC_ADDR_MODE, 32'(mi));
            settle(2);
            chk("error code", 32'h000D, 32'(ERR_CODE));
            chk("irq raised", 32'h1, 32'(IRQ));
            bus(1'b0, `LMHC_ADDR_STATUS, 32'h0);
            chk("status", 32'h01, 32'(rd[4:0]));
            settle(3);
            chk("irq cleared", 32'h0, 32'(IRQ));
            plc.pulse_backup();
            settle(6);
            chk("error active", 32'h0, 32'(ERR_ACTIVE));
            bus(1'b0, `LMHC_ADDR_STATE, 32'h0);
            chk("active mode", 32'(mi), 32'(rd[2:0]));
            settle(2);
            chk("outputs", 32'(tab[mi]), {16'h0, HEAT_OUT, COOL_OUT, EXT_HEAT_FLAG, EXT_COOL_FLAG});
        end
        bus(1'b1, `LMHC_ADDR_MASK, 32'h0);
        $display("test mode_table done");
    endtask

    task automatic t_write_err();
        logic [11:0] sa [4] = '{`LMHC_ADDR_STOPW1, `LMHC_ADDR_STOPW2, `LMHC_ADDR_STOPW3, `LMHC_ADDR_STOPW4};
        logic [15:0] sv [4] = '{16'h0001, 16'h0002, 16'h0002, 16'h0001};
        bus(1'b1, `LMHC_ADDR_RETAIN, 32'hF);
        bus(1'b1, `LMHC_ADDR_STOPW1, 32'h3);
        settle(1);
        chk("error code", 32'h0001, 32'(ERR_CODE));
        chk("irq masked", 32'h0, 32'(IRQ));
        bus(1'b0, `LMHC_ADDR_STOPW1, 32'h0);
        chk("stop word kept", 32'h0, 32'(rd[15:0]));
        plc.pulse_backup();
        settle(6);
        chk("error active", 32'h0, 32'(ERR_ACTIVE));
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, sa[i], 32'(sv[i]));
            bus(1'b0, sa[i], 32'h0);
            chk("stop word", 32'(sv[i]), 32'(rd[15:0]));
        end
        $display("test write_err done");
    endtask

    // Channel 2 retains, the others clear; each fault in turn in heating-cooling expanded mode
    task automatic t_faults();
        bus(1'b1, `LMHC_ADDR_RETAIN, 32'h2);
        bus(1'b1, `LMHC_ADDR_MODE, 32'h2);
        plc.pulse_backup();
        bus(1'b0, `LMHC_ADDR_STATUS, 32'h0);
        drive_req(4'hF, 4'h0);
        settle(2);
        chk("heat out", 32'h3C, 32'({HEAT_OUT, EXT_HEAT_FLAG}));
        for (int k = 0; k < 3; k++) begin
            plc.set_levels(k == 0, k == 2, k == 1);
            settle(5);
            chk("heat out", 32'h20, 32'({HEAT_OUT, EXT_HEAT_FLAG}));
            chk("run monitor", 32'h2, 32'(RUN_MON));
            if (k == 2) chk("applied stop", 32'h61, 32'(APPLIED_STOP));
            plc.set_levels(1'b0, 1'b0, 1'b0);
            settle(5);
            chk("heat out", 32'h3C, 32'({HEAT_OUT, EXT_HEAT_FLAG}));
        end
        bus(1'b0, `LMHC_ADDR_STATUS, 32'h0);
        chk("status", 32'h1C, 32'(rd[4:0]));
        $display("test faults done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence; takes well under a thousand cycles
    initial begin
        repeat (10) @(posedge CLK);
        RESET <= 1'b0;
        t_reset_values();
        t_mode_table();
        t_write_err();
        t_faults();
        tally_and_finish();
    end

    // Watchdog far beyond the expected run so only a hang reaches it
    initial begin
        repeat (20000) @(posedge CLK);
        err_total++;
        tally_and_finish();
    end
endmodule
